// file: core/htu_pkg.sv
package htu_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int NUM_W  = 7;
	localparam int SEG_W  = 8;
	localparam int OFF_W  = 16;
	localparam int VSC_W  = 2;
	localparam int NA     = 4;
	localparam int NB     = 8;
	localparam int NFLAG  = NA + NB;

	// Register indices on the plain register port
	localparam logic [ADDR_W-1:0] REG_TFR  = 3'h0;
	localparam logic [ADDR_W-1:0] REG_VSEG = 3'h1;
	localparam logic [ADDR_W-1:0] REG_CPU1 = 3'h2;
	localparam logic [ADDR_W-1:0] REG_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] REG_MASK = 3'h4;

	// Flag layout: class A in low bits, class B above
	localparam int FLG_SR0  = 0;
	localparam int FLG_SR1  = 4;
	localparam int VSC_LSB  = 0;

	localparam logic [SEG_W-1:0]  VSEG_RST = 8'h00;
	localparam logic [VSC_W-1:0]  VSC_RST  = 2'h0;
	localparam logic [NFLAG-1:0]  TFR_RST  = 12'h000;
	localparam int                BASE_SH  = 2;

	localparam logic [NUM_W-1:0] NUM_RESET = 7'h00;
	localparam logic [NUM_W-1:0] NUM_SR0   = 7'h02;
	localparam logic [NUM_W-1:0] NUM_STACK_OVERFLOW_FLAG = 7'h04;
	localparam logic [NUM_W-1:0] NUM_STACK_UNDERFLOW_FLAG = 7'h06;
	localparam logic [NUM_W-1:0] NUM_SBRK  = 7'h08;
	localparam logic [NUM_W-1:0] NUM_B     = 7'h0A;
	localparam logic [NUM_W-1:0] NUM_RSV_LO = 7'h0B;
	localparam logic [NUM_W-1:0] NUM_RSV_HI = 7'h0F;

	// Interrupt status bits
	localparam int ST_A   = 0;
	localparam int ST_B   = 1;
	localparam int ST_SW  = 2;
	localparam int ST_RSV = 3;
	localparam int NST    = 4;

	typedef enum logic [1:0] {HTU_PRIO_NONE, HTU_PRIO_B, HTU_PRIO_A, HTU_PRIO_RST} htu_prio_t;
	typedef enum logic [1:0] {HTU_KIND_RST, HTU_KIND_A, HTU_KIND_B, HTU_KIND_SW} htu_kind_t;
	typedef enum logic [1:0] {HTU_ST_RESET, HTU_ST_IDLE, HTU_ST_ISSUE} htu_state_t;
endpackage : htu_pkg

// file: core/htu_vec_if.sv
`timescale 1ns/1ps
interface htu_vec_if;
	logic [htu_pkg::NUM_W-1:0]         num;
	logic [htu_pkg::SEG_W-1:0]         seg;
	logic [htu_pkg::VSC_W-1:0]         vsc;
	logic [htu_pkg::SEG_W+htu_pkg::OFF_W-1:0] addr;
	modport calc (input num, input seg, input vsc, output addr);
	modport user (output num, output seg, output vsc, input addr);
endinterface : htu_vec_if

// file: core/htu_vec_calc.sv
`timescale 1ns/1ps
module htu_vec_calc (
	htu_vec_if.calc vif
);
	logic [htu_pkg::OFF_W-1:0] off;

	always_comb
	begin
		off = (htu_pkg::OFF_W)'({9'h0, vif.num} << (htu_pkg::BASE_SH + int'(vif.vsc)));
		vif.addr = {vif.seg, off};
	end
endmodule : htu_vec_calc

// file: core/htu_prio.sv
`timescale 1ns/1ps
module htu_prio #(
	parameter int N = 4
) (
	input  wire logic [N-1:0]         req,
	output logic      [$clog2(N)-1:0] idx,
	output logic                      any
);
	always_comb
	begin
		idx = '0;
		any = 1'b0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				idx = ($clog2(N))'(i);
				any = 1'b1;
			end
		end
	end
endmodule : htu_prio

// file: core/htu_top.sv
`timescale 1ns/1ps
module htu_top (
	input  wire logic [htu_pkg::NFLAG-1:0]  trap_ev,
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	input  wire logic                       sw_trap_req,
	input  wire logic [htu_pkg::NUM_W-1:0]  sw_trap_num,
	input  wire logic                       redirect_ack,
	input  wire logic                       svc_return,
	input  wire logic [htu_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [htu_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [htu_pkg::DATA_W-1:0] reg_rdata_q,
	output logic                            irq_q,
	output logic                            redirect_valid_q,
	output logic      [htu_pkg::NUM_W-1:0]  redirect_num_q,
	output logic      [23:0]                redirect_addr_q,
	output htu_pkg::htu_kind_t              redirect_kind_q,
	output logic                            irq_block_q
);
	htu_vec_if vif ();

	htu_pkg::htu_state_t              st_q, st_d;
	htu_pkg::htu_prio_t               cur_prio_q, cur_prio_d;
	htu_pkg::htu_prio_t               sav_prio_q, sav_prio_d;
	htu_pkg::htu_kind_t               kind_d;
	logic [htu_pkg::NFLAG-1:0]        tfr_q, tfr_d;
	logic [htu_pkg::NA-1:0]           pend_a_q, pend_a_d;
	logic                             pend_b_q, pend_b_d;
	logic                             sw_pend_q, sw_pend_d;
	logic [htu_pkg::NUM_W-1:0]        sw_num_q, sw_num_d;
	logic [htu_pkg::SEG_W-1:0]        vseg_q, vseg_d;
	logic [htu_pkg::VSC_W-1:0]        vsc_q, vsc_d;
	logic [htu_pkg::NST-1:0]          stat_q, stat_d;
	logic [htu_pkg::NST-1:0]          mask_q, mask_d;
	logic [htu_pkg::NST-1:0]          stat_ev;
	logic [htu_pkg::DATA_W-1:0]       rdata_d;
	logic                             irq_d;
	logic                             valid_d;
	logic [htu_pkg::NUM_W-1:0]        num_d;
	logic [23:0]                      addr_d;
	logic                             irq_block_d;
	logic                             issue;
	logic [htu_pkg::NUM_W-1:0]        sel_num;
	logic [$clog2(htu_pkg::NA)-1:0]   a_idx;
	logic                             a_any;

	htu_prio #(
		.N (htu_pkg::NA)
	) u_prio_a (
		.req (pend_a_q),
		.idx (a_idx),
		.any (a_any)
	);

	htu_vec_calc u_calc (
		.vif (vif.calc)
	);

	assign vif.num = sel_num;
	assign vif.seg = vseg_q;
	assign vif.vsc = vsc_q;

	// Trap selection and redirect sequencing
	always_comb
	begin
		st_d       = st_q;
		cur_prio_d = cur_prio_q;
		sav_prio_d = sav_prio_q;
		kind_d     = redirect_kind_q;
		sel_num    = htu_pkg::NUM_RESET;
		issue      = 1'b0;
		stat_ev    = '0;
		pend_a_d   = pend_a_q | trap_ev[htu_pkg::NA-1:0];
		pend_b_d   = pend_b_q | (|trap_ev[htu_pkg::NFLAG-1:htu_pkg::NA]);
		sw_pend_d  = sw_pend_q;
		sw_num_d   = sw_num_q;
		if (sw_trap_req && !sw_pend_q)
		begin
			sw_pend_d = 1'b1;
			sw_num_d  = sw_trap_num;
		end
		if (svc_return)
		begin
			cur_prio_d = sav_prio_q;
			sav_prio_d = htu_pkg::HTU_PRIO_NONE;
		end
		case (st_q)
			htu_pkg::HTU_ST_RESET:
			begin
				issue   = 1'b1;
				sel_num = htu_pkg::NUM_RESET;
				kind_d  = htu_pkg::HTU_KIND_RST;
			end
			htu_pkg::HTU_ST_IDLE:
			begin
				if (a_any && cur_prio_q < htu_pkg::HTU_PRIO_A)
				begin
					issue      = 1'b1;
					kind_d     = htu_pkg::HTU_KIND_A;
					sav_prio_d = cur_prio_q;
					cur_prio_d = htu_pkg::HTU_PRIO_A;
					stat_ev[htu_pkg::ST_A] = 1'b1;
					pend_a_d[a_idx] = trap_ev[a_idx];
					case (a_idx)
						2'd0: sel_num = htu_pkg::NUM_SR0;
						2'd1: sel_num = htu_pkg::NUM_STACK_OVERFLOW_FLAG;
						2'd2: sel_num = htu_pkg::NUM_STACK_UNDERFLOW_FLAG;
						default: sel_num = htu_pkg::NUM_SBRK;
					endcase
				end
				else if (pend_b_q && cur_prio_q < htu_pkg::HTU_PRIO_B)
				begin
					issue      = 1'b1;
					kind_d     = htu_pkg::HTU_KIND_B;
					sav_prio_d = cur_prio_q;
					cur_prio_d = htu_pkg::HTU_PRIO_B;
					stat_ev[htu_pkg::ST_B] = 1'b1;
					pend_b_d   = |trap_ev[htu_pkg::NFLAG-1:htu_pkg::NA];
					sel_num    = htu_pkg::NUM_B;
				end
				else if (sw_pend_q)
				begin
					issue     = 1'b1;
					kind_d    = htu_pkg::HTU_KIND_SW;
					sel_num   = sw_num_q;
					sw_pend_d = 1'b0;
					stat_ev[htu_pkg::ST_SW] = 1'b1;
					if (sw_num_q >= htu_pkg::NUM_RSV_LO && sw_num_q <= htu_pkg::NUM_RSV_HI)
					begin
						stat_ev[htu_pkg::ST_RSV] = 1'b1;
					end
				end
			end
			htu_pkg::HTU_ST_ISSUE:
			begin
				if (redirect_ack)
				begin
					st_d = htu_pkg::HTU_ST_IDLE;
				end
			end
			default:
			begin
				st_d = htu_pkg::HTU_ST_IDLE;
			end
		endcase
		if (issue)
		begin
			st_d = htu_pkg::HTU_ST_ISSUE;
		end
		valid_d = redirect_valid_q;
		num_d   = redirect_num_q;
		addr_d  = redirect_addr_q;
		if (issue)
		begin
			valid_d = 1'b1;
			num_d   = sel_num;
			addr_d  = vif.addr;
		end
		else if (st_q == htu_pkg::HTU_ST_ISSUE && redirect_ack)
		begin
			valid_d = 1'b0;
		end
		irq_block_d = (cur_prio_d != htu_pkg::HTU_PRIO_NONE);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_q             <= htu_pkg::HTU_ST_RESET;
			cur_prio_q       <= htu_pkg::HTU_PRIO_NONE;
			sav_prio_q       <= htu_pkg::HTU_PRIO_NONE;
			pend_a_q         <= '0;
			pend_b_q         <= 1'b0;
			sw_pend_q        <= 1'b0;
			sw_num_q         <= '0;
			redirect_valid_q <= 1'b0;
			redirect_num_q   <= '0;
			redirect_addr_q  <= '0;
			redirect_kind_q  <= htu_pkg::HTU_KIND_RST;
			irq_block_q      <= 1'b0;
		end
		else
		begin
			st_q             <= st_d;
			cur_prio_q       <= cur_prio_d;
			sav_prio_q       <= sav_prio_d;
			pend_a_q         <= pend_a_d;
			pend_b_q         <= pend_b_d;
			sw_pend_q        <= sw_pend_d;
			sw_num_q         <= sw_num_d;
			redirect_valid_q <= valid_d;
			redirect_num_q   <= num_d;
			redirect_addr_q  <= addr_d;
			redirect_kind_q  <= kind_d;
			irq_block_q      <= irq_block_d;
		end
	end

	// Register file, flags and interrupt
	always_comb
	begin
		// flags held until software writes one to clear
		tfr_d = tfr_q;
		if (reg_wr && reg_addr == htu_pkg::REG_TFR)
		begin
			tfr_d = tfr_q & ~reg_wdata[htu_pkg::NFLAG-1:0];
		end
		tfr_d  = tfr_d | trap_ev;
		vseg_d = vseg_q;
		vsc_d  = vsc_q;
		mask_d = mask_q;
		if (reg_wr && reg_addr == htu_pkg::REG_VSEG)
		begin
			vseg_d = reg_wdata[htu_pkg::SEG_W-1:0];
		end
		if (reg_wr && reg_addr == htu_pkg::REG_CPU1)
		begin
			vsc_d = reg_wdata[htu_pkg::VSC_LSB +: htu_pkg::VSC_W];
		end
		if (reg_wr && reg_addr == htu_pkg::REG_MASK)
		begin
			mask_d = reg_wdata[htu_pkg::NST-1:0];
		end
		stat_d  = stat_q;
		rdata_d = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				htu_pkg::REG_TFR:  rdata_d = DATA_PAD(tfr_q);
				htu_pkg::REG_VSEG: rdata_d = {8'h00, vseg_q};
				htu_pkg::REG_CPU1: rdata_d = {14'h0, vsc_q};
				htu_pkg::REG_STAT:
				begin
					rdata_d = {12'h000, stat_q};
					stat_d  = '0;
				end
				htu_pkg::REG_MASK: rdata_d = {12'h000, mask_q};
				default:           rdata_d = '0;
			endcase
		end
		stat_d = stat_d | stat_ev;
		irq_d  = |(stat_d & mask_d);
	end

	function automatic logic [htu_pkg::DATA_W-1:0] DATA_PAD(input logic [htu_pkg::NFLAG-1:0] v);
		DATA_PAD = {4'h0, v};
	endfunction : DATA_PAD

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			tfr_q       <= htu_pkg::TFR_RST;
			vseg_q      <= htu_pkg::VSEG_RST;
			vsc_q       <= htu_pkg::VSC_RST;
			stat_q      <= '0;
			mask_q      <= '0;
			reg_rdata_q <= '0;
			irq_q       <= 1'b0;
		end
		else
		begin
			tfr_q       <= tfr_d;
			vseg_q      <= vseg_d;
			vsc_q       <= vsc_d;
			stat_q      <= stat_d;
			mask_q      <= mask_d;
			reg_rdata_q <= rdata_d;
			irq_q       <= irq_d;
		end
	end

	a_flag_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|trap_ev) |=> ((tfr_q & $past(trap_ev)) == $past(trap_ev)))
		else $error("trap flag not set by its condition");

	a_class_a_num: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(redirect_valid_q && redirect_kind_q == htu_pkg::HTU_KIND_A)
		|-> (redirect_num_q inside {7'h02, 7'h04, 7'h06, 7'h08}))
		else $error("class A trap on wrong number");

	a_class_b_num: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(redirect_valid_q && redirect_kind_q == htu_pkg::HTU_KIND_B)
		|-> (redirect_num_q == 7'h0A && (!$rose(redirect_valid_q)
		|| redirect_addr_q[15:0] == 16'(16'h0028 << $past(vsc_q)))))
		else $error("class B trap not on shared vector");

	a_seg_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(redirect_valid_q) |-> (redirect_addr_q[23:16] == $past(vseg_q)))
		else $error("vector segment not from register");

	a_default_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($rose(redirect_valid_q) && $past(vsc_q) == 2'h0)
		|-> (redirect_addr_q[15:0] == {7'h00, redirect_num_q, 2'b00}))
		else $error("default spacing is not four bytes");

	a_hw_prompt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == htu_pkg::HTU_ST_IDLE && a_any && cur_prio_q < htu_pkg::HTU_PRIO_A)
		|=> (redirect_valid_q && redirect_kind_q == htu_pkg::HTU_KIND_A))
		else $error("class A trap not taken at once");

	a_block_reqs: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($rose(redirect_valid_q) && redirect_kind_q inside {htu_pkg::HTU_KIND_A,
		htu_pkg::HTU_KIND_B}) |-> irq_block_q ##1 (irq_block_q || $past(svc_return)))
		else $error("requests not blocked in trap service");

	a_reset_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !$past(rst_n)) |=> (redirect_valid_q && redirect_num_q == 7'h00
		&& redirect_kind_q == htu_pkg::HTU_KIND_RST))
		else $error("reset vector not taken first");

	a_rsv_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($rose(redirect_valid_q) && redirect_kind_q == htu_pkg::HTU_KIND_SW
		&& redirect_num_q inside {[7'h0B:7'h0F]}) |-> stat_q[htu_pkg::ST_RSV])
		else $error("reserved trap number not reported");
endmodule : htu_top

// file: verification/htu_seq_model.sv
`timescale 1ns/1ps
module htu_seq_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       redirect_valid_q,
	input  wire logic       ret_cmd,
	input  wire logic [3:0] ack_dly,
	output logic            redirect_ack,
	output logic            svc_return
);
	logic [3:0] cnt_q;
	logic       ack_q;
	logic       ret_q;

	// Take each redirect once, after ack_dly idle cycles
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			ret_q <= 1'b0;
		end
		else
		begin
			ack_q <= 1'b0;
			ret_q <= ret_cmd;
			if (redirect_valid_q && !ack_q)
			begin
				if (cnt_q == ack_dly)
				begin
					ack_q <= 1'b1;
					cnt_q <= 4'h0;
				end
				else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	assign redirect_ack = ack_q;
	assign svc_return   = ret_q;
endmodule : htu_seq_model

// file: verification/hardware_trap_unit_tb.sv
`timescale 1ns/1ps
module hardware_trap_unit_tb;
	logic               clk_sys     = 1'b0;
	logic               rst_n       = 1'b0;
	logic [11:0]        trap_ev     = 12'h000;
	logic               sw_trap_req = 1'b0;
	logic [6:0]         sw_trap_num = 7'h00;
	logic [2:0]         reg_addr    = 3'h0;
	logic [15:0]        reg_wdata   = 16'h0000;
	logic               reg_wr      = 1'b0;
	logic               reg_rd      = 1'b0;
	logic               ret_cmd     = 1'b0;
	logic [3:0]         ack_dly     = 4'h0;
	logic               redirect_ack;
	logic               svc_return;
	logic [15:0]        reg_rdata_q;
	logic               irq_q;
	logic               redirect_valid_q;
	logic [6:0]         redirect_num_q;
	logic [23:0]        redirect_addr_q;
	htu_pkg::htu_kind_t redirect_kind_q;
	logic               irq_block_q;
	int                 n_mismatch = 0;
	int                 tests_run  = 0;
	int                 cyc        = 0;

	htu_top htu_top_inst (.trap_ev(trap_ev), .clk_sys(clk_sys), .rst_n(rst_n),
		.sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num), .redirect_ack(redirect_ack),
		.svc_return(svc_return), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
		.redirect_valid_q(redirect_valid_q), .redirect_num_q(redirect_num_q),
		.redirect_addr_q(redirect_addr_q), .redirect_kind_q(redirect_kind_q),
		.irq_block_q(irq_block_q));

	htu_seq_model htu_seq_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.redirect_valid_q(redirect_valid_q), .ret_cmd(ret_cmd), .ack_dly(ack_dly),
		.redirect_ack(redirect_ack), .svc_return(svc_return));

	always #50 clk_sys = ~clk_sys;

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdc(input string nm, input logic [2:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(nm, 24'(e), 24'(reg_rdata_q));
	endtask : rdc

	task automatic redir(input logic [6:0] n, input logic [23:0] ad,
		input htu_pkg::htu_kind_t k);
		int i;
		i = 0;
		@(negedge clk_sys);
		while (redirect_valid_q !== 1'b1 && i < 40)
		begin
			@(negedge clk_sys);
			i++;
		end
		chk("redirect_valid", 24'h1, 24'(redirect_valid_q));
		chk("redirect_num", 24'(n), 24'(redirect_num_q));
		chk("redirect_addr", ad, redirect_addr_q);
		chk("redirect_kind", 24'(k), 24'(redirect_kind_q));
		i = 0;
		while (redirect_valid_q !== 1'b0 && i < 40)
		begin
			@(negedge clk_sys);
			i++;
		end
		chk("redirect_release", 24'h0, 24'(redirect_valid_q));
	endtask : redir

	task automatic ev(input logic [11:0] v);
		@(posedge clk_sys);
		trap_ev <= v;
		@(posedge clk_sys);
		trap_ev <= 12'h000;
	endtask : ev

	task automatic ret;
		@(posedge clk_sys);
		ret_cmd <= 1'b1;
		@(posedge clk_sys);
		ret_cmd <= 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask : ret

	task automatic t_reset;
		redir(7'h00, 24'h000000, htu_pkg::HTU_KIND_RST);
		rdc("trap_flags", htu_pkg::REG_TFR, 16'h0000);
		rdc("vector_segment", htu_pkg::REG_VSEG, 16'h0000);
		rdc("control_one", htu_pkg::REG_CPU1, 16'h0000);
		rdc("irq_mask", htu_pkg::REG_MASK, 16'h0000);
		wr(3'h5, 16'hFFFF);
		rdc("unmapped", 3'h5, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_class_a;
		int i;
		wr(htu_pkg::REG_MASK, 16'h0001);
		for (i = 0; i < 4; i++)
		begin
			ev(12'(1 << i));
			redir(7'(2 + 2 * i), 24'((2 + 2 * i) * 4), htu_pkg::HTU_KIND_A);
			chk("hw_block", 24'h1, 24'(irq_block_q));
			chk("irq", 24'h1, 24'(irq_q));
			rdc("trap_flags", htu_pkg::REG_TFR, 16'(1 << i));
			rdc("status", htu_pkg::REG_STAT, 16'h0001);
			@(negedge clk_sys);
			chk("irq", 24'h0, 24'(irq_q));
			wr(htu_pkg::REG_TFR, 16'(1 << i));
			rdc("trap_flags", htu_pkg::REG_TFR, 16'h0000);
			ret();
			chk("hw_block", 24'h0, 24'(irq_block_q));
		end
		wr(htu_pkg::REG_MASK, 16'h0000);
		$display("test class_a done");
	endtask : t_class_a

	task automatic t_class_b;
		int i;
		for (i = 4; i < 12; i++)
		begin
			ev(12'(1 << i));
			redir(7'h0A, 24'h000028, htu_pkg::HTU_KIND_B);
			rdc("trap_flags", htu_pkg::REG_TFR, 16'(1 << i));
			rdc("status", htu_pkg::REG_STAT, 16'h0002);
			wr(htu_pkg::REG_TFR, 16'(1 << i));
			ret();
		end
		$display("test class_b done");
	endtask : t_class_b

	task automatic t_spacing;
		int f;
		wr(htu_pkg::REG_VSEG, 16'h005A);
		rdc("vector_segment", htu_pkg::REG_VSEG, 16'h005A);
		for (f = 0; f < 4; f++)
		begin
			wr(htu_pkg::REG_CPU1, 16'(f));
			rdc("control_one", htu_pkg::REG_CPU1, 16'(f));
			ev(12'h002);
			redir(7'h04, {8'h5A, 16'(4 << (2 + f))}, htu_pkg::HTU_KIND_A);
			wr(htu_pkg::REG_TFR, 16'h0002);
			ret();
		end
		wr(htu_pkg::REG_CPU1, 16'h0000);
		wr(htu_pkg::REG_VSEG, 16'h0000);
		rdc("status", htu_pkg::REG_STAT, 16'h0001);
		$display("test spacing done");
	endtask : t_spacing

	task automatic t_soft;
		logic [6:0] nums [3];
		int i;
		nums = '{7'h7F, 7'h0C, 7'h00};
		wr(htu_pkg::REG_MASK, 16'h0008);
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk_sys);
			sw_trap_req <= 1'b1;
			sw_trap_num <= nums[i];
			@(posedge clk_sys);
			sw_trap_req <= 1'b0;
			redir(nums[i], 24'({nums[i], 2'b00}), htu_pkg::HTU_KIND_SW);
			chk("hw_block", 24'h0, 24'(irq_block_q));
			chk("irq", 24'(nums[i] == 7'h0C), 24'(irq_q));
			rdc("status", htu_pkg::REG_STAT, (nums[i] == 7'h0C) ? 16'h000C : 16'h0004);
		end
		wr(htu_pkg::REG_MASK, 16'h0000);
		$display("test soft done");
	endtask : t_soft

	task automatic t_prio;
		ack_dly <= 4'h5;
		ev(12'h013);
		redir(7'h02, 24'h000008, htu_pkg::HTU_KIND_A);
		repeat (6) @(negedge clk_sys);
		chk("redirect_valid", 24'h0, 24'(redirect_valid_q));
		ret();
		redir(7'h04, 24'h000010, htu_pkg::HTU_KIND_A);
		ret();
		redir(7'h0A, 24'h000028, htu_pkg::HTU_KIND_B);
		ev(12'h004);
		redir(7'h06, 24'h000018, htu_pkg::HTU_KIND_A);
		ret();
		ret();
		chk("hw_block", 24'h0, 24'(irq_block_q));
		wr(htu_pkg::REG_TFR, 16'h0017);
		rdc("trap_flags", htu_pkg::REG_TFR, 16'h0000);
		rdc("status", htu_pkg::REG_STAT, 16'h0003);
		$display("test prio done");
	endtask : t_prio

	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_class_a();
		t_class_b();
		t_spacing();
		t_soft();
		t_prio();
		complete_run();
	end
endmodule : hardware_trap_unit_tb
